// ===== design/serial_eeprom_pkg.sv
// Purpose: shared constants for the serial configuration memory
// Assumes: 20 MHz core clock, serial clock sampled from a pin
// Notes:   command framing is start bit, two-bit opcode, six-bit address
package serial_eeprom_pkg;
    // ==========================================================
    // geometry
    localparam int unsigned WORDS      = 64;
    localparam int unsigned WORD_BITS  = 16;
    localparam int unsigned ADDR_BITS  = 6;
    localparam int unsigned OP_BITS    = 2;
    localparam int unsigned HDR_BITS   = 1 + OP_BITS + ADDR_BITS;
    // ==========================================================
    // opcodes
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] OP_OTHER = 2'h0;
    // ==========================================================
    // timing and reset values
    localparam int unsigned CLK_MHZ     = 20;
    localparam int unsigned PROG_US     = 2000;
    localparam int unsigned PROG_CYCLES = PROG_US * CLK_MHZ;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    localparam logic [3:0]  CNT_RESET   = 4'h0;
    // ==========================================================
    // link states, gray along the write path idle-hdr-data-armed-prog-done-idle
    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'b000,
        ST_HDR   = 3'b001,
        ST_DATA  = 3'b011,
        ST_ARMED = 3'b010,
        ST_PROG  = 3'b110,
        ST_DONE  = 3'b100,
        ST_READ  = 3'b101
    } link_state_t;
endpackage : serial_eeprom_pkg

// ===== design/serial_eeprom.sv
// Purpose: device end of a three-wire serial configuration memory
// Assumes: chip select, serial clock and data in arrive from pins
// Notes:   storage is flip-flops; the programming time is shortened by parameter
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - store 64 words of 16 bits
// - respond only while chip select high
// - read bits leave at falling serial edges
// - capture data in at rising serial edges
// - data out low while programming runs
// - data out high when programming ends
module serial_eeprom #(
    parameter int unsigned PROG_CYCLES = serial_eeprom_pkg::PROG_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic chip_sel,
    input  wire logic ser_clk,
    input  wire logic data_in,
    output logic      data_out,
    output logic      data_out_oe_n,
    output logic      busy
);
    // ==========================================================
    // pin synchronisers
    logic [1:0] cs_sync_reg;
    logic [1:0] sck_sync_reg;
    logic [1:0] din_sync_reg;
    logic       sck_last_reg;
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cs_sync_reg  <= 2'h0;
            sck_sync_reg <= 2'h0;
            din_sync_reg <= 2'h0;
            sck_last_reg <= 1'b0;
        end
        else
        begin
            cs_sync_reg  <= {cs_sync_reg[0], chip_sel};
            sck_sync_reg <= {sck_sync_reg[0], ser_clk};
            din_sync_reg <= {din_sync_reg[0], data_in};
            sck_last_reg <= sck_sync_reg[1];
        end
    end
    // edges seen only on the second stage
    logic cs_hi;
    logic sck_rise;
    logic sck_fall;
    logic din_s;
    assign cs_hi    = cs_sync_reg[1];
    assign din_s    = din_sync_reg[1];
    assign sck_rise = sck_sync_reg[1] & ~sck_last_reg;
    assign sck_fall = ~sck_sync_reg[1] & sck_last_reg;
    // ==========================================================
    // storage
    logic [15:0] mem_reg [serial_eeprom_pkg::WORDS];
    logic [15:0] mem_next [serial_eeprom_pkg::WORDS];
    // ==========================================================
    // link state
    serial_eeprom_pkg::link_state_t state_reg, state_next;
    logic [3:0]  cnt_reg, cnt_next;
    logic [1:0]  op_reg, op_next;
    logic [5:0]  addr_reg, addr_next;
    logic [15:0] shift_reg, shift_next;
    logic        dout_reg, dout_next;
    logic        drive_reg, drive_next;
    logic [31:0] prog_reg, prog_next;
    // next-state logic; select low aborts anything but an armed or running write or erase
    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        op_next    = op_reg;
        addr_next  = addr_reg;
        shift_next = shift_reg;
        dout_next  = dout_reg;
        drive_next = drive_reg;
        prog_next  = prog_reg;
        mem_next   = mem_reg;
        unique case (state_reg)
            serial_eeprom_pkg::ST_IDLE:
            begin
                drive_next = 1'b0;
                // a high data-in bit at a rising edge is the start bit
                if (cs_hi && sck_rise && din_s)
                begin
                    state_next = serial_eeprom_pkg::ST_HDR;
                    cnt_next   = serial_eeprom_pkg::CNT_RESET;
                end
            end
            serial_eeprom_pkg::ST_HDR:
            begin
                if (!cs_hi)
                    state_next = serial_eeprom_pkg::ST_IDLE;
                else if (sck_rise)
                begin
                    shift_next = {shift_reg[14:0], din_s};
                    cnt_next   = cnt_reg + 4'h1;
                    if (cnt_reg == 4'(serial_eeprom_pkg::HDR_BITS - 2))
                    begin
                        op_next   = shift_reg[6:5];
                        addr_next = {shift_reg[4:0], din_s};
                        cnt_next  = serial_eeprom_pkg::CNT_RESET;
                        unique case (shift_reg[6:5])
                            serial_eeprom_pkg::OP_READ:
                            begin
                                shift_next = mem_reg[{shift_reg[4:0], din_s}];
                                state_next = serial_eeprom_pkg::ST_READ;
                            end
                            serial_eeprom_pkg::OP_WRITE:
                                state_next = serial_eeprom_pkg::ST_DATA;
                            serial_eeprom_pkg::OP_ERASE:
                                state_next = serial_eeprom_pkg::ST_ARMED;
                            serial_eeprom_pkg::OP_OTHER:
                                state_next = serial_eeprom_pkg::ST_IDLE;
                        endcase
                    end
                end
            end
            serial_eeprom_pkg::ST_DATA:
            begin
                if (!cs_hi)
                    state_next = serial_eeprom_pkg::ST_IDLE;
                else if (sck_rise)
                begin
                    shift_next = {shift_reg[14:0], din_s};
                    cnt_next   = cnt_reg + 4'h1;
                    if (cnt_reg == 4'hf)
                        state_next = serial_eeprom_pkg::ST_ARMED;
                end
            end
            serial_eeprom_pkg::ST_READ:
            begin
                // one bit per falling edge, msb first, driving until select drops
                if (!cs_hi)
                begin
                    state_next = serial_eeprom_pkg::ST_IDLE;
                    drive_next = 1'b0;
                end
                else if (sck_fall)
                begin
                    drive_next = 1'b1;
                    dout_next  = shift_reg[15];
                    shift_next = {shift_reg[14:0], 1'b0};
                end
            end
            serial_eeprom_pkg::ST_ARMED:
            begin
                // the low pulse on select launches the operation
                if (!cs_hi)
                begin
                    state_next = serial_eeprom_pkg::ST_PROG;
                    prog_next  = 32'h0;
                end
            end
            serial_eeprom_pkg::ST_PROG:
            begin
                drive_next = cs_hi;
                dout_next  = 1'b0;
                prog_next  = prog_reg + 32'h1;
                if (prog_reg == PROG_CYCLES - 1)
                begin
                    mem_next[addr_reg] = (op_reg == serial_eeprom_pkg::OP_WRITE)
                                         ? shift_reg : serial_eeprom_pkg::ERASED_WORD;
                    state_next = serial_eeprom_pkg::ST_DONE;
                end
            end
            serial_eeprom_pkg::ST_DONE:
            begin
                // ready shows until the host drops select
                drive_next = cs_hi;
                dout_next  = 1'b1;
                if (!cs_hi && drive_reg)
                    state_next = serial_eeprom_pkg::ST_IDLE;
            end
            default:
                state_next = serial_eeprom_pkg::ST_IDLE;
        endcase
    end
    // registers only; memory contents are not cleared by reset in spirit,
    // but flip-flop storage starts erased
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= serial_eeprom_pkg::ST_IDLE;
            cnt_reg   <= serial_eeprom_pkg::CNT_RESET;
            op_reg    <= serial_eeprom_pkg::OP_OTHER;
            addr_reg  <= 6'h0;
            shift_reg <= 16'h0;
            dout_reg  <= 1'b1;
            drive_reg <= 1'b0;
            prog_reg  <= 32'h0;
            for (int i = 0; i < serial_eeprom_pkg::WORDS; i++)
                mem_reg[i] <= serial_eeprom_pkg::ERASED_WORD;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            op_reg    <= op_next;
            addr_reg  <= addr_next;
            shift_reg <= shift_next;
            dout_reg  <= dout_next;
            drive_reg <= drive_next;
            prog_reg  <= prog_next;
            mem_reg   <= mem_next;
        end
    end
    // outputs; enable is active low
    assign data_out      = dout_reg;
    assign data_out_oe_n = ~drive_reg;
    assign busy          = (state_reg == serial_eeprom_pkg::ST_PROG);
endmodule : serial_eeprom
`default_nettype wire

// ===== dv/serial_eeprom_properties.sv
// Purpose: port checks for serial_eeprom
// Assumes: one core_clk domain, nrst async low
// Notes:   windows allow for the 3-cycle pin sync
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_properties #(
    parameter int unsigned PROG_CYCLES = serial_eeprom_pkg::PROG_CYCLES
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic chip_sel,
    input wire logic ser_clk,
    input wire logic data_in,
    input wire logic data_out,
    input wire logic data_out_oe_n,
    input wire logic busy
);
    // ==========================================================
    // busy length, too long to unroll as a repetition
    int unsigned busy_cnt_reg;
    int unsigned busy_cnt_next;
    always_comb busy_cnt_next = busy ? busy_cnt_reg + 1 : 0;
    always_ff @(posedge core_clk or negedge nrst)
        if (!nrst)
            busy_cnt_reg <= 0;
        else
            busy_cnt_reg <= busy_cnt_next;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    property p_sel_gate;
        !chip_sel [*6] |-> data_out_oe_n;
    endproperty
    a_sel_gate: assert property (p_sel_gate) else $error("pin driven while deselected");
    property p_busy_low;
        chip_sel [*7] ##0 busy |-> !data_out_oe_n && !data_out;
    endproperty
    a_busy_low: assert property (p_busy_low) else $error("busy not shown low");
    property p_busy_len;
        $fell(busy) |-> busy_cnt_reg == PROG_CYCLES;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("programming time off");
    property p_done;
        $fell(busy) && chip_sel |-> ##[0:2] (data_out && !data_out_oe_n);
    endproperty
    a_done: assert property (p_done) else $error("done level missing");
    property p_read_edge;
        $changed(data_out) && !data_out_oe_n && !$past(data_out_oe_n) |-> !$past(ser_clk, 2);
    endproperty
    a_read_edge: assert property (p_read_edge) else $error("out bit moved off falling edge");
    // select held high through the sync window cannot have launched programming
    property p_launch;
        chip_sel [*4] |=> !$rose(busy);
    endproperty
    a_launch: assert property (p_launch) else $error("programming began without pulse");
    // the done level must never show while programming still runs
    property p_busy_high;
        busy |-> !data_out || data_out_oe_n;
    endproperty
    a_busy_high: assert property (p_busy_high) else $error("done shown while busy");
endmodule : serial_eeprom_properties
bind serial_eeprom serial_eeprom_properties #(.PROG_CYCLES(PROG_CYCLES)) i_props (
    .core_clk(core_clk), .nrst(nrst), .chip_sel(chip_sel), .ser_clk(ser_clk),
    .data_in(data_in), .data_out(data_out), .data_out_oe_n(data_out_oe_n), .busy(busy));
`default_nettype wire

// ===== dv/serial_eeprom_host.sv
// Purpose: host controller model driving the serial memory pins
// Assumes: 8 core cycles per serial clock, clock idles low
// Notes:   a released data out reads as the inverse of its last level
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_host (
    input  wire logic core_clk,
    input  wire logic data_out,
    input  wire logic data_out_oe_n,
    output var logic  chip_sel,
    output var logic  ser_clk,
    output var logic  data_in
);
    // ==========================================================
    // no pull on data out: a released line shows the inverse of its last level,
    // so a bit sampled while the device is not driving comes back wrong
    wire logic seen = data_out_oe_n ? ~data_out : data_out;
    initial
    begin
        chip_sel = 1'b0;
        ser_clk  = 1'b0;
        data_in  = 1'b1;
    end
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step
    // one exchange; lo counts cycles seen busy, cyc the wait for done
    task automatic xfer(input logic [24:0] b, input int n, input bit rd, input bit pulse,
                        output logic [15:0] q, output int cyc, output int lo);
        q = 16'h0000;
        cyc = 0;
        lo = 0;
        chip_sel = 1'b1;
        for (int i = 0; i < n + (rd ? 16 : 0); i++)
        begin
            ser_clk = 1'b0;
            if (i < n)
                data_in = b[24 - i];
            step(4);
            ser_clk = 1'b1;
            step(4);
            if (i >= n)
                q[15 - (i - n)] = seen;
        end
        ser_clk = 1'b0;
        data_in = ~data_in;
        step(4);
        if (pulse)
        begin
            chip_sel = 1'b0;
            step(8);
            chip_sel = 1'b1;
            cyc = 8;
            // only a driven level counts; a released line says nothing about progress
            while (!(data_out_oe_n === 1'b0 && data_out === 1'b1) && cyc < 1000)
            begin
                lo += (data_out_oe_n === 1'b0 && data_out === 1'b0);
                step(1);
                cyc++;
            end
        end
        chip_sel = 1'b0;
        step(8);
    endtask : xfer
endmodule : serial_eeprom_host
`default_nettype wire

// ===== dv/serial_eeprom_tb.sv
// Purpose: self-checking bench for serial_eeprom
// Assumes: programming time shortened to 20 cycles
// Notes:   host model does all pin wiggling
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_tb;
    localparam int unsigned PC = 20;
    logic        core_clk = 1'b0;
    logic        nrst     = 1'b0;
    wire logic   chip_sel, ser_clk, data_in, data_out, data_out_oe_n, busy;
    logic [15:0] q;
    int          cyc, lo, err_count = 0, compares = 0;
    int          busy_cycles = 0;
    always #25 core_clk = ~core_clk;
    // cycles spent programming, read before and after the first write and the erase
    always @(posedge core_clk)
        if (busy === 1'b1)
            busy_cycles <= busy_cycles + 1;
    serial_eeprom #(.PROG_CYCLES(PC)) i_serial_eeprom (.core_clk(core_clk), .nrst(nrst),
        .chip_sel(chip_sel), .ser_clk(ser_clk), .data_in(data_in), .data_out(data_out),
        .data_out_oe_n(data_out_oe_n), .busy(busy));
    serial_eeprom_host i_serial_eeprom_host (.core_clk(core_clk), .data_out(data_out),
        .data_out_oe_n(data_out_oe_n), .chip_sel(chip_sel), .ser_clk(ser_clk),
        .data_in(data_in));
    // ==========================================================
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask : chk
    task automatic cmd(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d,
                       input int n, input bit rd, input bit pulse);
        i_serial_eeprom_host.xfer({1'b1, op, a, d}, n, rd, pulse, q, cyc, lo);
    endtask : cmd
    task automatic t_reset;
        chk("busy idle", 32'h0, busy);
        chk("oe idle", 32'h1, data_out_oe_n);
        cmd(serial_eeprom_pkg::OP_READ, 6'h00, 16'h0000, 9, 1, 0);
        chk("reset word", serial_eeprom_pkg::ERASED_WORD, q);
    endtask : t_reset
    task automatic t_write_read;
        int b0;
        b0 = busy_cycles;
        cmd(serial_eeprom_pkg::OP_WRITE, 6'h00, 16'h8001, 25, 0, 1);
        chk("busy seen low", 32'h1, lo > 0);
        chk("busy time", 32'h1, cyc >= PC && cyc <= PC + 10);
        chk("busy cycles", PC, busy_cycles - b0);
        cmd(serial_eeprom_pkg::OP_WRITE, 6'h3f, 16'h5a3c, 25, 0, 1);
        cmd(serial_eeprom_pkg::OP_READ, 6'h00, 16'h0000, 9, 1, 0);
        chk("word 0", 32'h8001, q);
        cmd(serial_eeprom_pkg::OP_READ, 6'h3f, 16'h0000, 9, 1, 0);
        chk("word 63", 32'h5a3c, q);
    endtask : t_write_read
    task automatic t_erase;
        int b0;
        b0 = busy_cycles;
        cmd(serial_eeprom_pkg::OP_ERASE, 6'h3f, 16'h0000, 9, 0, 1);
        chk("erase done", 32'h1, cyc >= PC && cyc <= PC + 10);
        chk("erase busy cycles", PC, busy_cycles - b0);
        cmd(serial_eeprom_pkg::OP_READ, 6'h3f, 16'h0000, 9, 1, 0);
        chk("erased word", serial_eeprom_pkg::ERASED_WORD, q);
    endtask : t_erase
    // unused opcode and a cut-short write must both leave word 0 alone
    task automatic t_refused;
        cmd(serial_eeprom_pkg::OP_OTHER, 6'h00, 16'h0000, 25, 0, 1);
        chk("no done for 00", 32'd1000, cyc);
        cmd(serial_eeprom_pkg::OP_WRITE, 6'h00, 16'h0000, 14, 0, 1);
        chk("no busy on abort", 32'h0, lo);
        cmd(serial_eeprom_pkg::OP_READ, 6'h00, 16'h0000, 9, 1, 0);
        chk("word 0 kept", 32'h8001, q);
    endtask : t_refused
    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        #2000000;
        err_count++;
        tally_and_finish();
    end
    initial
    begin
        repeat (4) @(posedge core_clk);
        #1 nrst = 1'b1;
        i_serial_eeprom_host.step(4);
        t_reset();
        t_write_read();
        t_erase();
        t_refused();
        tally_and_finish();
    end
endmodule : serial_eeprom_tb
`default_nettype wire
